// *** rtl/gdfl_pkg.sv ***
// Package with constants and types shared by both ends of the gate drive fault latch.
//
// Overview of operation
// [RQ1] Dead time 0.2 us per phase gate pair
// [RQ2] Controller adds any extra dead time itself
// [RQ3] No fault: gates follow phase commands
// [RQ4] Any fault blanks all gates, latched
// [RQ5] Latched fault pulls fault output low, open-drain
// [RQ6] Reset pulse re-arms only with phases off
// [RQ7] Stop input high latches fault
// [RQ8] Controller pulses reset before driving commands
// [RQ9] Four detector inputs latch fault
// [RQ10] Substrate over-temperature latches fault
// [RQ11] Controller stops phases after long overload
// [RQ12] Brake command active low drives brake gate
// [RQ13] Phase commands active low
// [RQ14] Controller command pulses at least 1.0 us
// [RQ15] Short circuit shutdown within 2.5 us
// [RQ16] Power-up holds gates off, fault shown
// [RQ17] Dead time counted in system clock cycles
package gdfl_pkg;
    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int DEAD_TIME_PS = 200000;
    localparam int MIN_PULSE_PS = 1000000;
    localparam int SC_SHUTDOWN_PS = 2500000;
    localparam int DEAD_CYC = (DEAD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SC_SHUTDOWN_CYC = SC_SHUTDOWN_PS / CLK_PERIOD_PS;
    localparam int DEAD_W = 4;
    localparam int PULSE_W = 6;
    localparam logic [DEAD_W-1:0] DEAD_CNT = DEAD_W'(DEAD_CYC);
    localparam logic [PULSE_W-1:0] PULSE_CNT = PULSE_W'(MIN_PULSE_CYC);
    // -------------------------------------------------------------------------
    // Widths and reset values
    // -------------------------------------------------------------------------
    localparam int PHASES = 3;
    localparam int CMDS = 6;
    localparam logic [CMDS-1:0] CMD_ALL_OFF = 6'h3F;
    localparam logic FAULT_AT_RESET = 1'h1;
    // Controller sequencer states.
    typedef enum logic [1:0] {
        GDFL_C_IDLE = 2'b00,
        GDFL_C_RST = 2'b01,
        GDFL_C_RUN = 2'b10
    } gdfl_ctl_e;
endpackage

// *** rtl/gdfl_if.sv ***
// Interface joining the power stage and the PWM controller.
`timescale 1ns/10ps
interface gdfl_if;
    logic [5:0] phase_cmd_n;
    logic brake_cmd_n;
    logic rst_pulse_n;
    logic stop;
    logic fault_n_o;
    logic fault_n_oe;
    logic fault_n;
    // Open-drain wire: low while driven, otherwise pulled high.
    assign fault_n = fault_n_oe ? fault_n_o : 1'b1;
    modport stage (
        input phase_cmd_n, brake_cmd_n, rst_pulse_n, stop,
        output fault_n_o, fault_n_oe
    );
    modport ctrl (
        output phase_cmd_n, brake_cmd_n, rst_pulse_n, stop,
        input fault_n
    );
endinterface

// *** rtl/gdfl_stage.sv ***
// Power stage end: dead time, fault latch and gate outputs.
`timescale 1ns/10ps
module gdfl_stage (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link to controller
    gdfl_if.stage lnk,
    // Protection detectors
    input wire logic det_short,
    input wire logic det_earth,
    input wire logic det_overtemp,
    input wire logic det_overvolt,
    // Gate outputs, active high, index 2k upper and 2k+1 lower of phase k
    output logic [5:0] gate_on,
    output logic brake_gate_on,
    output logic fault_led
);

    // -------------------------------------------------------------------------
    // Local types and helpers
    // -------------------------------------------------------------------------
    // Per-phase gate state; DEAD covers the enforced gap after any gate turn-off.
    typedef enum logic [1:0] {
        GDFL_PH_OFF = 2'b00,
        GDFL_PH_UPPER = 2'b01,
        GDFL_PH_LOWER = 2'b10,
        GDFL_PH_DEAD = 2'b11
    } gdfl_ph_e;

    // A low-active command asks for its gate unless the fault latch blanks it.
    function automatic logic gate_request(input logic cmd_n, input logic blank);
        return !cmd_n && !blank;
    endfunction

    // -------------------------------------------------------------------------
    // Trip sources
    // -------------------------------------------------------------------------
    logic trip_det;
    logic trip_stop;
    logic trip;

    assign trip_det = det_short | det_earth | det_overvolt | det_overtemp; // [RQ9] [RQ10]
    assign trip_stop = lnk.stop; // [RQ7]
    assign trip = trip_det | trip_stop; // [RQ4]

    // -------------------------------------------------------------------------
    // Re-arm pulse edge
    // -------------------------------------------------------------------------
    logic rst_prev_r, rst_prev_nxt;
    logic phases_off;
    logic rearm;

    always_comb
    begin
        rst_prev_nxt = lnk.rst_pulse_n;
    end

    always_ff @(posedge clk_sys)
    begin
        // Idle level after reset, so no false pulse end follows reset.
        if (sys_rst)
            rst_prev_r <= 1'b1;
        else
            rst_prev_r <= rst_prev_nxt;
    end

    assign phases_off = (lnk.phase_cmd_n == gdfl_pkg::CMD_ALL_OFF); // [RQ6]
    // Re-arm on the rising end of the low reset pulse with all phases off.
    assign rearm = !rst_prev_r && lnk.rst_pulse_n && phases_off; // [RQ6]

    // -------------------------------------------------------------------------
    // Fault latch
    // -------------------------------------------------------------------------
    logic fault_r, fault_nxt;

    // A trip in the same cycle as a re-arm wins, so no fault is ever lost.
    always_comb
    begin
        fault_nxt = fault_r;
        if (trip)
            fault_nxt = 1'b1; // [RQ4]
        else if (rearm)
            fault_nxt = 1'b0; // [RQ6]
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            fault_r <= gdfl_pkg::FAULT_AT_RESET; // [RQ16]
        else
            fault_r <= fault_nxt;
    end

    // -------------------------------------------------------------------------
    // Dead time per phase
    // -------------------------------------------------------------------------
    logic [5:0] gate_nxt;
    logic brake_nxt;

    genvar k;
    generate
        for (k = 0; k < gdfl_pkg::PHASES; k++)
        begin : g_ph
            gdfl_ph_e ph_r, ph_nxt;
            logic [gdfl_pkg::DEAD_W-1:0] dt_r, dt_nxt;
            logic hi_req, lo_req;

            assign hi_req = gate_request(lnk.phase_cmd_n[2*k], fault_nxt); // [RQ3] [RQ13]
            assign lo_req = gate_request(lnk.phase_cmd_n[2*k+1], fault_nxt); // [RQ3] [RQ13]

            // Both commands low would short the phase, so no gate switches on then; a gate already on stays on.
            always_comb
            begin
                ph_nxt = ph_r;
                dt_nxt = dt_r;
                case (ph_r)
                    GDFL_PH_UPPER:
                    begin
                        if (!hi_req)
                        begin
                            ph_nxt = GDFL_PH_DEAD;
                            dt_nxt = gdfl_pkg::DEAD_CNT; // [RQ1] [RQ17]
                        end
                    end
                    GDFL_PH_LOWER:
                    begin
                        if (!lo_req)
                        begin
                            ph_nxt = GDFL_PH_DEAD;
                            dt_nxt = gdfl_pkg::DEAD_CNT; // [RQ1] [RQ17]
                        end
                    end
                    GDFL_PH_DEAD:
                    begin
                        if (dt_r != '0)
                            dt_nxt = dt_r - 1'b1; // [RQ1]
                        else if (hi_req && !lo_req)
                            ph_nxt = GDFL_PH_UPPER;
                        else if (lo_req && !hi_req)
                            ph_nxt = GDFL_PH_LOWER;
                        else
                            ph_nxt = GDFL_PH_OFF;
                    end
                    GDFL_PH_OFF:
                    begin
                        if (hi_req && !lo_req)
                            ph_nxt = GDFL_PH_UPPER; // [RQ3]
                        else if (lo_req && !hi_req)
                            ph_nxt = GDFL_PH_LOWER; // [RQ3]
                    end
                    default:
                    begin
                        ph_nxt = GDFL_PH_DEAD;
                        dt_nxt = gdfl_pkg::DEAD_CNT;
                    end
                endcase
            end

            always_ff @(posedge clk_sys)
            begin
                // Start in dead time so no gate switches on straight out of reset.
                if (sys_rst)
                begin
                    ph_r <= GDFL_PH_DEAD;
                    dt_r <= gdfl_pkg::DEAD_CNT;
                end
                else
                begin
                    ph_r <= ph_nxt;
                    dt_r <= dt_nxt;
                end
            end

            assign gate_nxt[2*k] = (ph_nxt == GDFL_PH_UPPER); // [RQ3]
            assign gate_nxt[2*k+1] = (ph_nxt == GDFL_PH_LOWER); // [RQ3]
        end
    endgenerate

    assign brake_nxt = gate_request(lnk.brake_cmd_n, fault_nxt); // [RQ12]

    // -------------------------------------------------------------------------
    // Output registers
    // -------------------------------------------------------------------------
    logic fault_led_nxt;
    logic od_oe_nxt;

    always_comb
    begin
        fault_led_nxt = fault_nxt; // [RQ5]
        od_oe_nxt = fault_nxt; // [RQ5]
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            gate_on <= 6'h00; // [RQ16]
            brake_gate_on <= 1'b0;
            fault_led <= gdfl_pkg::FAULT_AT_RESET;
            lnk.fault_n_o <= 1'b0;
            lnk.fault_n_oe <= gdfl_pkg::FAULT_AT_RESET; // [RQ16]
        end
        else
        begin
            gate_on <= gate_nxt; // [RQ4] [RQ15]
            brake_gate_on <= brake_nxt;
            fault_led <= fault_led_nxt;
            // The pin only ever pulls low; the enable alone carries the fault.
            lnk.fault_n_o <= 1'b0;
            lnk.fault_n_oe <= od_oe_nxt; // [RQ5]
        end
    end

endmodule // gdfl_stage

// *** rtl/gdfl_ctrl.sv ***
// Controller end: reset pulse sequencing and command forwarding.
`timescale 1ns/10ps
module gdfl_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link to power stage
    gdfl_if.ctrl lnk,
    // User side
    input wire logic [5:0] user_phase_n,
    input wire logic user_brake_n,
    input wire logic user_stop,
    input wire logic user_rearm,
    input wire logic user_overload,
    output logic running,
    output logic fault_seen
);
    gdfl_pkg::gdfl_ctl_e st_r, st_nxt;
    logic [gdfl_pkg::PULSE_W-1:0] cnt_r, cnt_nxt;
    logic [5:0] ph_nxt;
    logic br_nxt, rst_nxt, stop_nxt;
    // -------------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ph_nxt = gdfl_pkg::CMD_ALL_OFF; // [RQ8]
        br_nxt = 1'b1;
        rst_nxt = 1'b1;
        stop_nxt = user_stop;
        case (st_r)
            gdfl_pkg::GDFL_C_IDLE:
            begin
                st_nxt = gdfl_pkg::GDFL_C_RST;
                cnt_nxt = gdfl_pkg::PULSE_CNT;
            end
            gdfl_pkg::GDFL_C_RST:
            begin
                rst_nxt = 1'b0; // [RQ6] [RQ8] [RQ14]
                if (cnt_r != '0)
                    cnt_nxt = cnt_r - 1'b1;
                else
                begin
                    rst_nxt = 1'b1;
                    st_nxt = gdfl_pkg::GDFL_C_RUN;
                end
            end
            gdfl_pkg::GDFL_C_RUN:
            begin
                // The user waveforms carry extra dead time and pulse widths.
                ph_nxt = user_overload ? gdfl_pkg::CMD_ALL_OFF : user_phase_n; // [RQ2] [RQ11]
                br_nxt = user_brake_n;
                if (user_rearm)
                begin
                    ph_nxt = gdfl_pkg::CMD_ALL_OFF;
                    st_nxt = gdfl_pkg::GDFL_C_IDLE;
                end
            end
            default:
                st_nxt = gdfl_pkg::GDFL_C_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st_r <= gdfl_pkg::GDFL_C_IDLE;
            cnt_r <= '0;
            lnk.phase_cmd_n <= gdfl_pkg::CMD_ALL_OFF;
            lnk.brake_cmd_n <= 1'b1;
            lnk.rst_pulse_n <= 1'b1;
            lnk.stop <= 1'b0;
            running <= 1'b0;
            fault_seen <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            lnk.phase_cmd_n <= ph_nxt;
            lnk.brake_cmd_n <= br_nxt;
            lnk.rst_pulse_n <= rst_nxt;
            lnk.stop <= stop_nxt;
            running <= (st_nxt == gdfl_pkg::GDFL_C_RUN);
            fault_seen <= !lnk.fault_n;
        end
    end
endmodule // gdfl_ctrl

// *** tb/gdfl_link_properties.sv ***
// Concurrent checks on the link between the power stage and the controller.
`timescale 1ns/10ps
module gdfl_link_properties (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Link and gates
    input wire logic [5:0] phase_cmd_n,
    input wire logic rst_pulse_n,
    input wire logic stop,
    input wire logic fault_n_oe,
    input wire logic fault_n,
    input wire logic det_short,
    input wire logic det_other,
    input wire logic [5:0] gate_on
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    a_stop_trips: assert property (stop |=> !fault_n)
        else $error("stop did not latch a fault");
    a_short_blanks: assert property (det_short |=> gate_on == 6'h00)
        else $error("short circuit did not blank gates");
    a_fault_blanks: assert property (fault_n_oe && $past(fault_n_oe) |-> gate_on == 6'h00)
        else $error("gate on while fault latched");
    a_od_pulls: assert property (fault_n_oe |-> !fault_n)
        else $error("fault line not pulled low");
    a_rearm_refused: assert property ($rose(rst_pulse_n) && phase_cmd_n != 6'h3F && !fault_n
        |=> !fault_n)
        else $error("re-arm taken with a phase on");
    a_rearm_clears: assert property ($rose(rst_pulse_n) && phase_cmd_n == 6'h3F && !stop
        && !det_short && !det_other |=> fault_n)
        else $error("valid re-arm ignored");
    a_dead_up: assert property ($fell(gate_on[0]) |-> !gate_on[1] [*8])
        else $error("lower gate on inside dead time");
    a_dead_down: assert property ($fell(gate_on[1]) |-> !gate_on[0] [*8])
        else $error("upper gate on inside dead time");
    a_phase_off: assert property (phase_cmd_n[2] |=> !gate_on[2])
        else $error("gate on with its command high");
endmodule // gdfl_link_properties

// *** tb/gdfl_tb_top.sv ***
// Self-checking bench for both ends of the gate drive fault latch.
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module gdfl_tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] det = 4'h0;
    logic [5:0] user_phase_n = 6'h3F;
    logic user_brake_n = 1'b1;
    logic user_stop = 1'b0;
    logic user_rearm = 1'b0;
    logic user_overload = 1'b0;
    logic [5:0] gate_on;
    logic brake_gate_on;
    logic fault_led;
    logic running;
    logic fault_seen;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    // -------------------------------------------------------------------------
    // Both ends and the checker
    // -------------------------------------------------------------------------
    gdfl_if lnk_if ();
    gdfl_stage gdfl_stage_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .lnk(lnk_if),
        .det_short(det[0]), .det_earth(det[1]), .det_overtemp(det[2]), .det_overvolt(det[3]),
        .gate_on(gate_on), .brake_gate_on(brake_gate_on), .fault_led(fault_led));
    gdfl_ctrl gdfl_ctrl_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .lnk(lnk_if),
        .user_phase_n(user_phase_n), .user_brake_n(user_brake_n), .user_stop(user_stop),
        .user_rearm(user_rearm), .user_overload(user_overload), .running(running),
        .fault_seen(fault_seen));
    gdfl_link_properties gdfl_link_properties_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .phase_cmd_n(lnk_if.phase_cmd_n), .rst_pulse_n(lnk_if.rst_pulse_n),
        .stop(lnk_if.stop), .fault_n_oe(lnk_if.fault_n_oe), .fault_n(lnk_if.fault_n),
        .det_short(det[0]), .det_other(|det[3:1]), .gate_on(gate_on));
    // -------------------------------------------------------------------------
    // Clock, timeout and helpers
    // -------------------------------------------------------------------------
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            complete_run();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // Phases off, then a one-cycle request that starts a new reset pulse.
    task automatic rearm();
        user_phase_n = 6'h3F;
        user_brake_n = 1'b1;
        step(2);
        user_rearm = 1'b1;
        step(1);
        user_rearm = 1'b0;
        step(50);
    endtask
    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial
    begin
        step(6);
        sys_rst = 1'b0;
        `CHK({lnk_if.fault_n, gate_on}, 7'h00)
        step(50);
        `CHK({lnk_if.fault_n, running}, 2'h3)
        user_phase_n = 6'h3E;
        user_brake_n = 1'b0;
        step(3);
        `CHK(gate_on, 6'h01)
        `CHK(brake_gate_on, 1'b1)
        user_phase_n = 6'h3D;
        step(4);
        `CHK(gate_on, 6'h00)
        step(10);
        `CHK(gate_on, 6'h02)
        user_phase_n = 6'h2B;
        step(3);
        `CHK(gate_on, 6'h14)
        user_phase_n = 6'h17;
        step(4);
        `CHK(gate_on, 6'h00)
        step(10);
        `CHK(gate_on, 6'h28)
        user_overload = 1'b1;
        step(3);
        `CHK(gate_on, 6'h00)
        user_overload = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            user_phase_n = 6'h3E;
            user_brake_n = 1'b0;
            step(12);
            `CHK(gate_on, 6'h01)
            {user_stop, det} = 5'h01 << i;
            step(3);
            `CHK(gate_on, 6'h00)
            `CHK(brake_gate_on, 1'b0)
            `CHK({lnk_if.fault_n, fault_led}, 2'h1)
            {user_stop, det} = 5'h00;
            step(3);
            `CHK({fault_seen, gate_on}, 7'h40)
            rearm();
            `CHK(lnk_if.fault_n, 1'b1)
        end
        complete_run();
    end
endmodule // gdfl_tb_top
